// file: vcpf_top.sv
// video capture port front end with axi4-lite registers
//
// Contract
// R1 - source raises valid only with real pixels; only valid samples are taken
// R2 - each field-sync falling edge closes the field and starts another
// R3 - line-sync level at field-sync fall marks the ended field odd or even
// R4 - each active line-sync edge starts a new scanline; edge is configurable
// R5 - pixels sampled on rising, falling or both edges of sample clock
// R6 - upper pixel byte used only when 16-bit width is configured
// R7 - general-purpose bus is never 16-bit while upper byte carries video
// R8 - in capture mode the video-enable pin is the high-active valid input
// R9 - in capture mode the dot-clock enable pin is the field-sync input
// R10 - each pixel word goes downstream with line, field and odd flags
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
`include "vcpf_map.svh"
module vcpf_top
  import vcpf_pkg::*;
#(
  parameter int FIFO_DEPTH = `VCPF_FIFO_DEPTH
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] pixel_in_bus,
  input wire logic pixel_sample_clock,
  input wire logic feature_video_enable_pin,
  input wire logic feature_dotclk_enable_pin,
  input wire logic line_sync_in,
  output logic dotclk_buf_out,
  output logic gp_bus_wide,
  output logic capture_active
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [15:0] pix_s;
  logic [3:0] ctl_s;
  vcpf_sync #(.W(16)) u_sync_pix (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in(pixel_in_bus),
    .sync_out(pix_s)
  );
  vcpf_sync #(.W(4)) u_sync_ctl (
    .aclk(aclk),
    .aresetn(aresetn),
    .async_in({line_sync_in, feature_dotclk_enable_pin,
               feature_video_enable_pin, pixel_sample_clock}),
    .sync_out(ctl_s)
  );
  wire pclk_s = ctl_s[0];
  wire vld_s = ctl_s[1];
  wire vs_s = ctl_s[2];
  wire hs_s = ctl_s[3];

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  logic [`VCPF_CFG_W-1:0] cfg_q;
  logic pclk_q;
  logic vs_q;
  logic hs_q;
  wire cap_mode = (cfg_q[`VCPF_CFG_MODE_HI:`VCPF_CFG_MODE_LO] == `VCPF_MODE_CAPTURE);
  wire wide = cfg_q[`VCPF_CFG_WIDE];
  wire line_fall = cfg_q[`VCPF_CFG_LFALL];
  vcpf_edge_t edge_sel;
  assign edge_sel = vcpf_edge_t'(cfg_q[`VCPF_CFG_EDGE_HI:`VCPF_CFG_EDGE_LO]);

  // ----------------------------------------
  // edge detection
  // ----------------------------------------
  wire pclk_rise = pclk_s & ~pclk_q;
  wire pclk_fall = ~pclk_s & pclk_q;
  // R5 selectable sample edge
  wire pclk_hit = (pclk_rise & (edge_sel == VCPF_EDGE_RISE || edge_sel == VCPF_EDGE_BOTH))
                | (pclk_fall & (edge_sel == VCPF_EDGE_FALL || edge_sel == VCPF_EDGE_BOTH));
  // R9 field sync taken from dot-clock enable pin
  wire vs_fall = cap_mode & ~vs_s & vs_q;
  // R4 configurable active line edge
  wire hs_act = cap_mode & (line_fall ? (~hs_s & hs_q) : (hs_s & ~hs_q));
  // R1 R8 only valid-qualified samples in capture mode
  wire pix_take = cap_mode & pclk_hit & vld_s;

  // ----------------------------------------
  // line and field tracking
  // ----------------------------------------
  logic sol_pend_q;
  logic sof_pend_q;
  logic field_odd_q;
  logic [15:0] fcnt_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pclk_q <= 1'b0;
      vs_q <= 1'b0;
      hs_q <= 1'b0;
    end else begin
      pclk_q <= pclk_s;
      vs_q <= vs_s;
      hs_q <= hs_s;
    end
  end
  // R2 R4 a new edge beats the consuming pixel
  wire sol_pend_d = hs_act | vs_fall | (sol_pend_q & ~pix_take);
  wire sof_pend_d = vs_fall | (sof_pend_q & ~pix_take);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sol_pend_q <= 1'b0;
      sof_pend_q <= 1'b0;
      field_odd_q <= 1'b0;
      fcnt_q <= 16'h0000;
    end else begin
      sol_pend_q <= sol_pend_d;
      sof_pend_q <= sof_pend_d;
      // R3 classify ended field
      field_odd_q <= vs_fall ? hs_s : field_odd_q;
      fcnt_q <= vs_fall ? 16'(fcnt_q + 16'h0001) : fcnt_q;
    end
  end

  // ----------------------------------------
  // capture stage into fifo
  // ----------------------------------------
  // the source cannot be stalled: a full stage drops the pixel and flags it
  logic stg_valid_q;
  logic [`VCPF_W_BITS-1:0] stg_q;
  logic ovf_q;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [`VCPF_W_BITS-1:0] fifo_out;
  logic [LW-1:0] fifo_level;
  wire stg_free = ~stg_valid_q | fifo_in_ready;
  wire stg_load = pix_take & stg_free;
  wire pix_drop = pix_take & ~stg_free;
  // R6 upper byte only in 16-bit width
  wire [15:0] pix_word = {wide ? pix_s[15:8] : 8'h00, pix_s[7:0]};
  // R10 flags travel with the word
  wire [`VCPF_W_BITS-1:0] stg_d = {field_odd_q, sof_pend_q, sol_pend_q, pix_word};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stg_valid_q <= 1'b0;
      stg_q <= '0;
    end else begin
      stg_valid_q <= stg_load | (stg_valid_q & ~fifo_in_ready);
      stg_q <= stg_load ? stg_d : stg_q;
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  wire aw_take = s_axi_awvalid & awready_q;
  wire w_take = s_axi_wvalid & wready_q;
  wire do_wr = aw_full_q & w_full_q & ~bvalid_q;
  wire aw_full_d = (aw_full_q | aw_take) & ~do_wr;
  wire w_full_d = (w_full_q | w_take) & ~do_wr;
  wire wr_cfg = do_wr & (aw_addr_q == `VCPF_A_CFG);
  wire wr_stat = do_wr & (aw_addr_q == `VCPF_A_STAT);
  wire wr_hit = wr_cfg | wr_stat;
  wire ar_take = s_axi_arvalid & arready_q;
  wire rvalid_d = ar_take | (rvalid_q & ~s_axi_rready);
  wire rd_cfg = (s_axi_araddr == `VCPF_A_CFG);
  wire rd_stat = (s_axi_araddr == `VCPF_A_STAT);
  wire rd_fcnt = (s_axi_araddr == `VCPF_A_FCNT);
  wire rd_data = (s_axi_araddr == `VCPF_A_DATA);
  wire rd_hit = rd_cfg | rd_stat | rd_fcnt | rd_data;
  // reading data pops one word; empty reads show valid low
  wire fifo_pop = ar_take & rd_data;
  wire [31:0] stat_word = {{(24-LW){1'b0}}, fifo_level, 5'h00,
                           capture_active, field_odd_q, ovf_q};
  wire [31:0] data_word = {fifo_out_valid, {(31-`VCPF_W_BITS){1'b0}},
                           fifo_out_valid ? fifo_out : {`VCPF_W_BITS{1'b0}}};
  wire [31:0] rd_mux = rd_cfg ? {{(32-`VCPF_CFG_W){1'b0}}, cfg_q}
                     : rd_stat ? stat_word
                     : rd_fcnt ? {16'h0000, fcnt_q}
                     : rd_data ? data_word : 32'h0000_0000;
  wire [`VCPF_CFG_W-1:0] cfg_wr = {w_strb_q[1] ? w_data_q[8] : cfg_q[8],
                                   w_strb_q[0] ? w_data_q[7:0] : cfg_q[7:0]};
  // overflow: write one clears, a new drop wins
  wire ovf_clr = wr_stat & w_strb_q[0] & w_data_q[`VCPF_ST_OVF];
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      awready_q <= 1'b0;
      wready_q <= 1'b0;
    end else begin
      aw_full_q <= aw_full_d;
      w_full_q <= w_full_d;
      aw_addr_q <= aw_take ? s_axi_awaddr : aw_addr_q;
      w_data_q <= w_take ? s_axi_wdata : w_data_q;
      w_strb_q <= w_take ? s_axi_wstrb : w_strb_q;
      awready_q <= ~aw_full_d;
      wready_q <= ~w_full_d;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `VCPF_RESP_OK;
      cfg_q <= `VCPF_CFG_RST;
      ovf_q <= 1'b0;
    end else begin
      bvalid_q <= do_wr | (bvalid_q & ~s_axi_bready);
      bresp_q <= do_wr ? (wr_hit ? `VCPF_RESP_OK : `VCPF_RESP_SLVERR) : bresp_q;
      cfg_q <= wr_cfg ? cfg_wr : cfg_q;
      ovf_q <= pix_drop | (ovf_q & ~ovf_clr);
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `VCPF_RESP_OK;
    end else begin
      arready_q <= ~rvalid_d;
      rvalid_q <= rvalid_d;
      rdata_q <= ar_take ? rd_mux : rdata_q;
      rresp_q <= ar_take ? (rd_hit ? `VCPF_RESP_OK : `VCPF_RESP_SLVERR) : rresp_q;
    end
  end

  // ----------------------------------------
  // pixel fifo
  // ----------------------------------------
  vcpf_fifo #(.W(`VCPF_W_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(stg_valid_q),
    .in_ready(fifo_in_ready),
    .in_data(stg_q),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out),
    .level(fifo_level)
  );

  // ----------------------------------------
  // pin mode outputs
  // ----------------------------------------
  logic dotclk_q;
  logic gp_wide_q;
  logic cap_act_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dotclk_q <= 1'b0;
      gp_wide_q <= 1'b0;
      cap_act_q <= 1'b0;
    end else begin
      // R9 pin no longer steers dot-clock buffer
      dotclk_q <= ~cap_mode & vs_s;
      // R7 no 16-bit general-purpose use while video owns upper byte
      gp_wide_q <= cfg_q[`VCPF_CFG_GP16] & ~(cap_mode & wide);
      cap_act_q <= cap_mode;
    end
  end
  assign dotclk_buf_out = dotclk_q;
  assign gp_bus_wide = gp_wide_q;
  assign capture_active = cap_act_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_valid_gates_take: assert property (pix_take |-> vld_s && pclk_hit) // R1
    else $error("pixel taken without valid sample");
  a_field_restart: assert property (vs_fall |=> sof_pend_q && sol_pend_q) // R2
    else $error("field fall did not start a new field");
  a_field_class: assert property (vs_fall |=> field_odd_q == $past(hs_s)) // R3
    else $error("field class not taken from line sync");
  a_line_restart: assert property (hs_act |=> sol_pend_q) // R4
    else $error("active line edge did not start a line");
  a_edge_rise_only: assert property (pix_take && edge_sel == VCPF_EDGE_RISE |-> pclk_rise) // R5
    else $error("sample taken on wrong clock edge");
  a_narrow_upper: assert property (stg_load && !wide |=> stg_q[15:8] == 8'h00) // R6
    else $error("upper byte used in 8-bit width");
  a_gp_not_wide: assert property (cap_mode && wide |=> !gp_bus_wide) // R7
    else $error("general-purpose bus wide during 16-bit capture");
  a_mode_gates_take: assert property (!cap_mode |-> !pix_take) // R8
    else $error("pixel taken outside capture mode");
  a_dotclk_free: assert property (cap_mode |=> !dotclk_buf_out) // R9
    else $error("dot-clock buffer steered in capture mode");
  a_word_flags: assert property (stg_load && sof_pend_q |=> stg_q[`VCPF_W_SOF] && stg_valid_q) // R10
    else $error("start of field flag lost");
  a_wide_upper: assert property (stg_load && wide |=> stg_q[15:8] == $past(pix_s[15:8])) // R6
    else $error("upper byte lost in 16-bit width");
  a_lower_byte: assert property (stg_load |=> stg_q[7:0] == $past(pix_s[7:0])) // R6
    else $error("lower byte not taken from pixel bus");
  a_odd_word: assert property (stg_load |=> stg_q[`VCPF_W_ODD] == $past(field_odd_q)) // R10
    else $error("odd flag not carried with word");
  a_field_count: assert property (vs_fall |=> fcnt_q == $past(fcnt_q) + 16'h0001) // R2
    else $error("ended field not counted");
  a_line_flag: assert property (stg_load && sol_pend_q |=> stg_q[`VCPF_W_SOL]) // R4
    else $error("start of line flag lost");
  // covers mark the main scenarios
  c_pixel: cover property (pix_take ##[1:20] pix_take);
  c_field: cover property (vs_fall ##[1:200] pix_take);
  c_drop: cover property (pix_drop);
  c_line: cover property (hs_act ##[1:200] pix_take);
  c_odd_field: cover property (vs_fall && hs_s);
endmodule // vcpf_top

// file: vcpf_map.svh
// register map, field positions and reset values of the video capture front end
`ifndef VCPF_MAP_SVH
`define VCPF_MAP_SVH
`define VCPF_A_CFG 8'h00
`define VCPF_A_STAT 8'h04
`define VCPF_A_FCNT 8'h08
`define VCPF_A_DATA 8'h0c
`define VCPF_CFG_W 9
`define VCPF_CFG_RST 9'h000
`define VCPF_CFG_MODE_HI 1
`define VCPF_CFG_MODE_LO 0
`define VCPF_CFG_WIDE 4
`define VCPF_CFG_EDGE_HI 6
`define VCPF_CFG_EDGE_LO 5
`define VCPF_CFG_LFALL 7
`define VCPF_CFG_GP16 8
`define VCPF_MODE_CAPTURE 2'h1
`define VCPF_ST_OVF 0
`define VCPF_ST_ODD 1
`define VCPF_ST_ACT 2
`define VCPF_ST_CNT_LO 8
`define VCPF_W_SOL 16
`define VCPF_W_SOF 17
`define VCPF_W_ODD 18
`define VCPF_W_BITS 19
`define VCPF_D_VALID 31
`define VCPF_RESP_OK 2'h0
`define VCPF_RESP_SLVERR 2'h2
`define VCPF_FIFO_DEPTH 16
`endif

// file: vcpf_pkg.sv
// types shared by the video capture front end
package vcpf_pkg;
  typedef enum logic [1:0] {
    VCPF_EDGE_NONE,
    VCPF_EDGE_RISE,
    VCPF_EDGE_FALL,
    VCPF_EDGE_BOTH
  } vcpf_edge_t;
endpackage

// file: vcpf_sync.sv
// two flip-flop level synchroniser, one per bit
`timescale 1ns/1ns
module vcpf_sync #(
  parameter int W = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  // meta_q feeds only sync_q
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  assign sync_out = sync_q;
endmodule // vcpf_sync

// file: vcpf_fifo.sv
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ns
module vcpf_fifo #(
  parameter int W = 19,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data,
  output logic [$clog2(DEPTH):0] level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  assign in_ready = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem[rd_q];
  assign level = cnt_q;
  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_q] <= in_data;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? AW'(wr_q + 1'b1) : wr_q;
      rd_q <= pop ? AW'(rd_q + 1'b1) : rd_q;
      cnt_q <= (AW+1)'(cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
    end
  end
endmodule // vcpf_fifo

// file: vcpf_src_model.sv
// video source model driving the capture pins of the front end
`timescale 1ns/1ns
module vcpf_src_model (
  input wire logic aclk,
  output logic [15:0] pix,
  output logic pclk,
  output logic valid,
  output logic fsync,
  output logic lsync
);
  // ----------------------------------------
  // idle levels, sample clock stands still
  // ----------------------------------------
  initial begin
    pix = 16'h0000;
    pclk = 1'b0;
    valid = 1'b0;
    fsync = 1'b1;
    lsync = 1'b0;
  end
  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // high valid only around a real pixel
  task automatic pixel(input logic [15:0] d, input logic v);
    // 160 ns sample clock: four cycles high, four low between pixels
    pix <= d;
    valid <= v;
    step(1);
    pclk <= 1'b1;
    step(4);
    pclk <= 1'b0;
    step(2);
    // released bus shows the inverse so a stale pixel never passes
    pix <= ~d;
    valid <= 1'b0;
    step(1);
  endtask
  // field sync falls with line level set
  task automatic field_end(input logic lvl);
    lsync <= lvl;
    step(4);
    fsync <= 1'b0;
    step(6);
    fsync <= 1'b1;
    step(6);
  endtask
  // line sync edge of either direction
  task automatic line_set(input logic lvl);
    lsync <= lvl;
    step(6);
  endtask
endmodule // vcpf_src_model

// file: testbench.sv
// self-checking bench for the video capture front end
`timescale 1ns/1ns
`include "vcpf_map.svh"
module testbench;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] rdata;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic awready, wready, bvalid, arready, rvalid;
  logic [15:0] pix;
  logic pclk, vld, fsync, lsync, dclk_out, gp_wide, cap_act;
  logic [31:0] rd;
  logic [1:0] rsp;
  int mismatches = 0;
  int tests_run = 0;
  always #10 aclk = ~aclk;
  vcpf_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .pixel_in_bus(pix), .pixel_sample_clock(pclk),
    .feature_video_enable_pin(vld), .feature_dotclk_enable_pin(fsync),
    .line_sync_in(lsync), .dotclk_buf_out(dclk_out), .gp_bus_wide(gp_wide),
    .capture_active(cap_act));
  vcpf_src_model src_u (.aclk(aclk), .pix(pix), .pclk(pclk), .valid(vld),
    .fsync(fsync), .lsync(lsync));
  // ----------------------------------------
  // report and bus tasks
  // ----------------------------------------
  task automatic finish_test();
    $display("compares %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic hang();
    mismatches++;
    finish_test();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    // one edge apart from the last release, and lets a falling-edge pixel land
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      n++;
      if (n > 50) hang();
    end while (!bvalid);
    rsp = bresp;
    bready <= 1'b0;
  endtask
  task automatic rdr(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      n++;
      if (n > 50) hang();
    end while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    check(rd, e);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (4) @(posedge aclk);
    rc(`VCPF_A_CFG, 32'h0);
    check(rsp, `VCPF_RESP_OK);
    rc(8'h10, 32'h0);
    check(rsp, `VCPF_RESP_SLVERR);
    wr(8'h14, 32'h1);
    check(rsp, `VCPF_RESP_SLVERR);
    check(dclk_out, 1'b1);
    wr(`VCPF_A_CFG, 32'h110);
    repeat (3) @(posedge aclk);
    check(gp_wide, 1'b1);
    check(cap_act, 1'b0);
    wr(`VCPF_A_CFG, 32'h111);
    repeat (3) @(posedge aclk);
    check(gp_wide, 1'b0);
    check(dclk_out, 1'b0);
    check(cap_act, 1'b1);
    wr(`VCPF_A_CFG, 32'h101);
    repeat (3) @(posedge aclk);
    check(gp_wide, 1'b1);
    // narrow width, rising edge
    wr(`VCPF_A_CFG, 32'h21);
    src_u.field_end(1'b1);
    rc(`VCPF_A_STAT, 32'h6);
    rc(`VCPF_A_FCNT, 32'h1);
    src_u.pixel(16'ha55a, 1'b1);
    rc(`VCPF_A_DATA, 32'h8007005a);
    src_u.pixel(16'h1111, 1'b0);
    rc(`VCPF_A_DATA, 32'h0);
    // wide width, falling pixel edge, falling line edge active
    wr(`VCPF_A_CFG, 32'hd1);
    src_u.pixel(16'h1234, 1'b1);
    rc(`VCPF_A_DATA, 32'h80041234);
    src_u.line_set(1'b0);
    src_u.pixel(16'h4321, 1'b1);
    rc(`VCPF_A_DATA, 32'h80054321);
    src_u.line_set(1'b1);
    src_u.pixel(16'h0f0f, 1'b1);
    rc(`VCPF_A_DATA, 32'h80040f0f);
    src_u.field_end(1'b0);
    rc(`VCPF_A_STAT, 32'h4);
    rc(`VCPF_A_FCNT, 32'h2);
    src_u.pixel(16'hbeef, 1'b1);
    rc(`VCPF_A_DATA, 32'h8003beef);
    // both edges give two words, no edge gives none
    wr(`VCPF_A_CFG, 32'h71);
    src_u.pixel(16'hc3c3, 1'b1);
    rc(`VCPF_A_DATA, 32'h8000c3c3);
    rc(`VCPF_A_DATA, 32'h8000c3c3);
    rc(`VCPF_A_DATA, 32'h0);
    wr(`VCPF_A_CFG, 32'h11);
    src_u.pixel(16'h5a5a, 1'b1);
    rc(`VCPF_A_DATA, 32'h0);
    // fill past the fifo while nobody drains, then empty it
    wr(`VCPF_A_CFG, 32'h21);
    src_u.field_end(1'b1);
    for (int i = 0; i < 18; i++) begin
      src_u.pixel(16'h0040 + 16'(i), 1'b1);
    end
    rc(`VCPF_A_STAT, 32'h1007);
    for (int i = 0; i < 17; i++) begin
      rdr(`VCPF_A_DATA);
      check(rd & 32'h8000ffff, 32'h80000040 + 32'(i));
    end
    rc(`VCPF_A_DATA, 32'h0);
    wr(`VCPF_A_STAT, 32'h1);
    rc(`VCPF_A_STAT, 32'h6);
    finish_test();
  end
endmodule // testbench
